// ==== src/arx_pkg.sv ====
//==============================================================================
// Contract
// (RULE_01) sample sixteen per bit, eight in double speed
// (RULE_02) idle: falling edge starts detection, sample one
// (RULE_03) start vote on samples 8-10 or 4-6
// (RULE_04) start mostly high: reject, hunt next edge
// (RULE_05) accepted start realigns bit phase every frame
// (RULE_06) sequencer: sixteen or eight states per bit
// (RULE_07) data and parity bits: centre majority vote
// (RULE_08) recover through first stop, ignore others
// (RULE_09) first stop voted zero sets frame error
// (RULE_10) next start edge right after stop vote
// (RULE_11) select bit one means double speed reception
// (RULE_12) five to ten data plus parity bits
// (RULE_13) remote transmitter keeps half the rate tolerance
// (RULE_14) frame error stored with its frame
// (RULE_15) two-flop synchroniser, high line means idle
//==============================================================================
package arx_pkg;

  //============================================================================
  // sequencer figures
  localparam logic [4:0] ARX_SPB_NORMAL        = 5'h10; // samples per bit, normal
  localparam logic [4:0] ARX_SPB_DOUBLE        = 5'h08; // samples per bit, double speed
  localparam logic [4:0] ARX_VOTE_FIRST_NORMAL = 5'h08; // first centre sample, normal
  localparam logic [4:0] ARX_VOTE_FIRST_DOUBLE = 5'h04; // first centre sample, double
  localparam logic [4:0] ARX_VOTE_SPAN         = 5'h02; // last vote = first + span
  localparam logic [4:0] ARX_SAMPLE_FIRST      = 5'h01; // number of the first low sample

  //============================================================================
  // frame size and reset values
  localparam logic [3:0] ARX_BITS_MIN   = 4'h5;  // data plus parity, least
  localparam logic [3:0] ARX_BITS_MAX   = 4'ha;  // data plus parity, most
  localparam logic       ARX_LINE_IDLE  = 1'b1;  // idle line level
  localparam int         ARX_DATA_W     = 10;    // widest character plus parity
  localparam int         ARX_BUF_DEPTH  = 2;     // receive buffer entries

  //============================================================================
  // receiver states, gray along idle-start-data-stop
  typedef enum logic [1:0] {
    ARX_IDLE  = 2'b00,
    ARX_START = 2'b01,
    ARX_DATA  = 2'b11,
    ARX_STOP  = 2'b10
  } arx_state_e;

  //============================================================================
  // two-of-three vote
  function automatic logic arx_majority(input logic [2:0] s);
    arx_majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : arx_majority

  // samples per bit for the mode
  function automatic logic [4:0] arx_spb(input logic dbl);
    arx_spb = dbl ? ARX_SPB_DOUBLE : ARX_SPB_NORMAL;
  endfunction : arx_spb

  // first centre sample for the mode
  function automatic logic [4:0] arx_vote_first(input logic dbl);
    arx_vote_first = dbl ? ARX_VOTE_FIRST_DOUBLE : ARX_VOTE_FIRST_NORMAL;
  endfunction : arx_vote_first

endpackage : arx_pkg

// ==== src/arx_rx_fifo.sv ====
`timescale 1ns/10ps
module arx_rx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 2
) (
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic             push_w;
  logic             pop_w;

  //============================================================================
  // handshakes
  assign in_ready_o  = (count_q != CNT_FULL);
  assign out_valid_o = (count_q != '0);
  assign push_w      = in_valid_i && in_ready_o;
  assign pop_w       = out_valid_o && out_ready_i;
  assign out_data_o  = mem_q[rd_ptr_q];

  //============================================================================
  // storage, frame and its error flag travel as one word
  always_ff @(posedge clock_i) begin
    if (push_w) begin
      mem_q[wr_ptr_q] <= in_data_i; // [RULE_14]
    end
  end

  // pointers and fill count
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push_w) begin
        wr_ptr_q <= (wr_ptr_q == PTR_LAST) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop_w) begin
        rd_ptr_q <= (rd_ptr_q == PTR_LAST) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push_w && !pop_w) begin
        count_q <= count_q + 1'b1;
      end else if (pop_w && !push_w) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  //============================================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  fill_bound_a : assert property (count_q <= CNT_FULL) // [RULE_14]
    else $error("receive buffer count above depth");

  stall_hold_a : assert property ( // [RULE_14]
    (!in_ready_o && !out_ready_i) |=> (!in_ready_o && out_data_o == $past(out_data_o)))
    else $error("full buffer changed while stalled");

endmodule : arx_rx_fifo

// ==== src/arx_rx_recovery.sv ====
`timescale 1ns/10ps
module arx_rx_recovery (
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  input  wire logic       sample_tick_i,
  input  wire logic       double_speed_select_i,
  input  wire logic [3:0] frame_bits_i,
  input  wire logic       rx_serial_i,
  output logic [9:0]      rx_data_o,
  output logic            frame_error_flag_o,
  output logic            rx_valid_o,
  input  wire logic       rx_ready_i,
  output logic            overrun_o,
  output logic            busy_o
);

  localparam int FW = arx_pkg::ARX_DATA_W + 1;

  arx_pkg::arx_state_e state_q;
  logic             sync1_q;
  logic             sync2_q;
  logic             prev_q;
  logic             mode_q;
  logic [3:0]       bits_q;
  logic [4:0]       sample_q;
  logic [3:0]       bit_cnt_q;
  logic [1:0]       votes_q;
  logic [9:0]       shift_q;
  logic             overrun_q;
  logic             line_w;
  logic [4:0]       lim_w;
  logic [4:0]       first_w;
  logic [4:0]       last_w;
  logic             bit_w;
  logic             edge_w;
  logic             decide_w;
  logic             wrap_w;
  logic [4:0]       sample_num_w;
  logic             push_w;
  logic             buf_ready_w;
  logic [9:0]       push_data_w;
  logic [3:0]       clamp_bits_w;
  logic [FW-1:0]    head_w;

  //============================================================================
  // line synchroniser, resets to idle level
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sync1_q <= arx_pkg::ARX_LINE_IDLE;
      sync2_q <= arx_pkg::ARX_LINE_IDLE;
    end else begin
      sync1_q <= rx_serial_i; // [RULE_15]
      sync2_q <= sync1_q;     // [RULE_15]
    end
  end

  //============================================================================
  // sequencer decode for the latched mode
  assign line_w   = sync2_q;
  assign lim_w    = arx_pkg::arx_spb(mode_q);        // [RULE_01] [RULE_06] [RULE_11]
  assign first_w  = arx_pkg::arx_vote_first(mode_q); // [RULE_03]
  assign last_w   = 5'(first_w + arx_pkg::ARX_VOTE_SPAN);
  assign bit_w    = arx_pkg::arx_majority({votes_q, line_w}); // [RULE_07]
  assign edge_w   = sample_tick_i && (state_q == arx_pkg::ARX_IDLE)
                    && prev_q && !line_w;                     // [RULE_02] [RULE_15]
  assign wrap_w   = sample_tick_i && (sample_q == lim_w);
  // number of the sample taken on this tick; sample_q still names the one before,
  // so deciding on sample_q alone would vote one sample late
  assign sample_num_w = (sample_q == lim_w) ? arx_pkg::ARX_SAMPLE_FIRST
                                            : 5'(sample_q + 1'b1); // [RULE_06]
  assign decide_w = sample_tick_i && (state_q != arx_pkg::ARX_IDLE)
                    && (sample_num_w == last_w); // [RULE_03] [RULE_07]
  assign push_w   = (state_q == arx_pkg::ARX_STOP) && decide_w; // [RULE_08]

  // frame size held inside the supported span
  always_comb begin
    if (frame_bits_i < arx_pkg::ARX_BITS_MIN) begin
      clamp_bits_w = arx_pkg::ARX_BITS_MIN; // [RULE_12]
    end else if (frame_bits_i > arx_pkg::ARX_BITS_MAX) begin
      clamp_bits_w = arx_pkg::ARX_BITS_MAX; // [RULE_12]
    end else begin
      clamp_bits_w = frame_bits_i;
    end
  end

  //============================================================================
  // previous line sample, taken on every tick for edge search
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      prev_q <= arx_pkg::ARX_LINE_IDLE;
    end else if (sample_tick_i) begin
      prev_q <= line_w;
    end
  end

  // mode and size latched at each start edge
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      mode_q <= 1'b0;
      bits_q <= arx_pkg::ARX_BITS_MAX;
    end else if (edge_w) begin
      mode_q <= double_speed_select_i; // [RULE_11]
      bits_q <= clamp_bits_w;          // [RULE_12]
    end
  end

  //============================================================================
  // receiver state
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      state_q <= arx_pkg::ARX_IDLE;
    end else begin
      case (state_q)
        arx_pkg::ARX_IDLE: begin
          if (edge_w) begin
            state_q <= arx_pkg::ARX_START; // [RULE_02]
          end
        end
        arx_pkg::ARX_START: begin
          if (decide_w && bit_w) begin
            state_q <= arx_pkg::ARX_IDLE;  // [RULE_04]
          end else if (wrap_w) begin
            state_q <= arx_pkg::ARX_DATA;  // [RULE_05]
          end
        end
        arx_pkg::ARX_DATA: begin
          if (wrap_w && bit_cnt_q == bits_q) begin
            state_q <= arx_pkg::ARX_STOP;  // [RULE_08]
          end
        end
        arx_pkg::ARX_STOP: begin
          if (decide_w) begin
            state_q <= arx_pkg::ARX_IDLE;  // [RULE_08] [RULE_10]
          end
        end
        default: begin
          state_q <= arx_pkg::ARX_IDLE;
        end
      endcase
    end
  end

  //============================================================================
  // sample number within the bit, restarted by each start edge
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      sample_q <= '0;
    end else if (edge_w) begin
      sample_q <= arx_pkg::ARX_SAMPLE_FIRST; // [RULE_02] [RULE_05]
    end else if (sample_tick_i && state_q != arx_pkg::ARX_IDLE) begin
      sample_q <= sample_num_w; // [RULE_06]
    end
  end

  // first two centre samples kept for the vote
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      votes_q <= '0;
    end else if (sample_tick_i && sample_num_w >= first_w && sample_num_w < last_w) begin
      votes_q <= {votes_q[0], line_w}; // [RULE_03] [RULE_07]
    end
  end

  // bit count and shift register, lsb first
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      bit_cnt_q <= '0;
      shift_q   <= '0;
    end else if (edge_w) begin
      bit_cnt_q <= '0;
    end else if (state_q == arx_pkg::ARX_DATA && decide_w) begin
      bit_cnt_q <= bit_cnt_q + 1'b1;
      shift_q   <= {bit_w, shift_q[9:1]}; // [RULE_07]
    end
  end

  //============================================================================
  // frame into the buffer, stop vote gives the error flag
  assign push_data_w = shift_q >> (arx_pkg::ARX_BITS_MAX - bits_q);

  arx_rx_fifo #(
    .WIDTH (FW),
    .DEPTH (arx_pkg::ARX_BUF_DEPTH)
  ) u_fifo (
    .clock_i     (clock_i),
    .srst_i      (srst_i),
    .in_valid_i  (push_w),
    .in_ready_o  (buf_ready_w),
    .in_data_i   ({!bit_w, push_data_w}), // [RULE_09] [RULE_14]
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (head_w)
  );

  assign rx_data_o          = head_w[9:0];
  assign frame_error_flag_o = head_w[FW-1]; // [RULE_14]
  assign busy_o             = (state_q != arx_pkg::ARX_IDLE);
  assign overrun_o          = overrun_q;

  // lost frame when both entries are held
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= push_w && !buf_ready_w;
    end
  end

  //============================================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);

  edge_start_a : assert property ( // [RULE_02]
    edge_w |=> (state_q == arx_pkg::ARX_START && sample_q == 5'h01))
    else $error("start edge not taken as sample one");

  idle_line_a : assert property ( // [RULE_15]
    (state_q == arx_pkg::ARX_IDLE && line_w) |=> state_q == arx_pkg::ARX_IDLE)
    else $error("left idle while line high");

  noise_reject_a : assert property ( // [RULE_04]
    (state_q == arx_pkg::ARX_START && decide_w && bit_w) |=> state_q == arx_pkg::ARX_IDLE)
    else $error("noisy start bit was not rejected");

  sample_range_a : assert property ( // [RULE_01]
    (state_q != arx_pkg::ARX_IDLE) |-> (sample_q >= 5'h01 && sample_q <= (mode_q ? 5'h08 : 5'h10)))
    else $error("sample number outside bit period");

  vote_point_a : assert property ( // [RULE_03]
    (state_q == arx_pkg::ARX_START && decide_w) |=> sample_q == (mode_q ? 5'h06 : 5'h0a))
    else $error("start vote at wrong sample");

  realign_a : assert property ( // [RULE_05]
    (state_q == arx_pkg::ARX_START && wrap_w) |=> (state_q == arx_pkg::ARX_DATA
      && sample_q == 5'h01 && bit_cnt_q == 4'h0))
    else $error("data phase not aligned to start bit");

  stop_error_a : assert property ( // [RULE_09]
    (push_w && buf_ready_w && !bit_w && !rx_valid_o)
      |=> (rx_valid_o && frame_error_flag_o))
    else $error("zero stop bit did not set frame error");

  early_start_a : assert property ( // [RULE_10]
    push_w |=> (state_q == arx_pkg::ARX_IDLE && !busy_o))
    else $error("receiver not ready after stop vote");

  bit_count_a : assert property ( // [RULE_08]
    (state_q == arx_pkg::ARX_STOP) |-> bit_cnt_q == bits_q)
    else $error("stop reached with wrong bit count");

  // sequencing inside a frame
  mode_hold_a : assert property ( // [RULE_11]
    (state_q != arx_pkg::ARX_IDLE) |=> mode_q == $past(mode_q))
    else $error("speed mode changed inside a frame");

  size_span_a : assert property ( // [RULE_12]
    bits_q >= arx_pkg::ARX_BITS_MIN && bits_q <= arx_pkg::ARX_BITS_MAX)
    else $error("frame size outside supported span");

  tick_gate_a : assert property ( // [RULE_01]
    !sample_tick_i |=> sample_q == $past(sample_q))
    else $error("sample number moved without a tick");

  bit_shift_a : assert property ( // [RULE_07]
    (state_q == arx_pkg::ARX_DATA && decide_w) |=> shift_q[9] == $past(bit_w))
    else $error("voted bit not shifted in");

  count_step_a : assert property ( // [RULE_08]
    (state_q == arx_pkg::ARX_DATA && decide_w) |=> bit_cnt_q == 4'($past(bit_cnt_q) + 1))
    else $error("bit count did not step on a data vote");

  stop_wait_a : assert property ( // [RULE_08]
    (state_q == arx_pkg::ARX_STOP && !decide_w) |=> state_q == arx_pkg::ARX_STOP)
    else $error("stop bit left before its vote");

  // frame completion and buffer
  frame_ok_a : assert property ( // [RULE_09]
    (push_w && buf_ready_w && bit_w && !rx_valid_o)
      |=> (rx_valid_o && !frame_error_flag_o))
    else $error("good stop bit flagged as frame error");

  error_pair_a : assert property ( // [RULE_14]
    (rx_valid_o && !rx_ready_i) |=> (frame_error_flag_o == $past(frame_error_flag_o)
      && rx_data_o == $past(rx_data_o)))
    else $error("head frame and its flag split while waiting");

  overrun_a : assert property ( // [RULE_14]
    (push_w && !buf_ready_w) |=> overrun_o)
    else $error("dropped frame not flagged");

  // main scenarios

  good_frame_c   : cover property (push_w && bit_w);
  framing_c      : cover property (push_w && !bit_w);
  noise_c        : cover property (state_q == arx_pkg::ARX_START && decide_w && bit_w);
  double_frame_c : cover property (push_w && mode_q);
  overrun_c      : cover property (push_w && !buf_ready_w);

endmodule : arx_rx_recovery

// ==== tb/arx_tx_model.sv ====
`timescale 1ns/10ps
//==============================================================================
// remote transmitter: one line sample per tick, changed at the falling edge
module arx_tx_model (
  input  wire logic clock_i,
  input  wire logic sample_tick_i,
  output logic      rx_serial_o
);
  logic line_q;

  assign rx_serial_o = line_q;

  // line idles high from time zero
  initial line_q = 1'b1;

  // step to just after the next tick, exact rate so no bit-rate error
  task automatic wait_tick();
    do @(posedge clock_i); while (sample_tick_i !== 1'b1);
    @(negedge clock_i);
  endtask : wait_tick

  // one frame: start, n bits lsb first, stop of stop_len samples
  task automatic send(input logic [9:0] data, input int n, input logic dbl,
                      input logic stop_v, input int stop_len, input logic glitch);
    int b;
    int s;
    int spb;
    logic v;
    spb = dbl ? 8 : 16;
    for (b = 0; b < n + 2; b++) begin
      v = (b == 0) ? 1'b0 : (b <= n) ? data[b-1] : stop_v;
      for (s = 1; s <= ((b == n + 1) ? stop_len : spb); s++) begin
        wait_tick();
        // flip one centre sample when asked
        line_q = v ^ (glitch && b != 0 && s == (dbl ? 5 : 9));
      end
    end
    // short stop leaves the next start right after the vote
    if (stop_len >= spb) begin
      wait_tick();
      line_q = 1'b1;
    end
  endtask : send

  // low pulse of len samples, then idle
  task automatic spike(input int len);
    repeat (len) begin
      wait_tick();
      line_q = 1'b0;
    end
    wait_tick();
    line_q = 1'b1;
  endtask : spike
endmodule : arx_tx_model

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
  logic       clock_i;
  logic       srst_i;
  logic       sample_tick_i = 1'b0;
  logic       double_speed_select_i;
  logic [3:0] frame_bits_i;
  logic       rx_ready_i;
  wire        rx_serial;
  logic [9:0] rx_data_o;
  logic       frame_error_flag_o;
  logic       rx_valid_o;
  logic       overrun_o;
  logic       busy_o;
  int         n_fail;
  int         cmp_count;
  int         ovr_cnt = 0;
  int         tick_cnt = 0;
  int         ovr_before;

  //============================================================================
  // design and far side
  arx_rx_recovery u_dut (
    .clock_i(clock_i), .srst_i(srst_i), .sample_tick_i(sample_tick_i),
    .double_speed_select_i(double_speed_select_i), .frame_bits_i(frame_bits_i),
    .rx_serial_i(rx_serial), .rx_data_o(rx_data_o),
    .frame_error_flag_o(frame_error_flag_o), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i), .overrun_o(overrun_o), .busy_o(busy_o)
  );
  arx_tx_model u_tx (.clock_i(clock_i), .sample_tick_i(sample_tick_i), .rx_serial_o(rx_serial));

  //============================================================================
  // clock, tick every fourth cycle, overrun pulse counter
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(negedge clock_i) begin
    tick_cnt <= (tick_cnt + 1) % 4;
    sample_tick_i <= (tick_cnt == 3);
  end
  always @(posedge clock_i) if (overrun_o === 1'b1) ovr_cnt <= ovr_cnt + 1;

  //============================================================================
  // shared helpers
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk

  task automatic cfg(input logic dbl, input logic [3:0] n);
    @(negedge clock_i);
    double_speed_select_i = dbl;
    frame_bits_i = n;
  endtask : cfg

  // wait for a frame, compare error flag and data, then take it
  task automatic pop_chk(input logic fe, input logic [9:0] d);
    int i;
    // let the previous release pass a clock edge before the next pop
    @(negedge clock_i);
    for (i = 0; i < 3000 && rx_valid_o !== 1'b1; i++) @(negedge clock_i);
    chk({10'h000, rx_valid_o}, 11'h001, "no frame delivered");
    chk({frame_error_flag_o, rx_data_o}, {fe, d}, "frame contents");
    rx_ready_i = 1'b1;
    @(negedge clock_i);
    rx_ready_i = 1'b0;
  endtask : pop_chk

  task automatic wrap_up();
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  //============================================================================
  // scenarios
  task automatic t_modes();
    cfg(1'b0, 4'h8);
    u_tx.send(10'h0a5, 8, 1'b0, 1'b1, 16, 1'b0);
    pop_chk(1'b0, 10'h0a5);
    cfg(1'b1, 4'h8);
    u_tx.send(10'h03c, 8, 1'b1, 1'b1, 8, 1'b0);
    pop_chk(1'b0, 10'h03c);
  endtask : t_modes

  task automatic t_sizes();
    cfg(1'b0, 4'h5);
    u_tx.send(10'h2b5, 5, 1'b0, 1'b1, 16, 1'b0);
    pop_chk(1'b0, 10'h015);
    cfg(1'b1, 4'ha);
    u_tx.send(10'h2b5, 10, 1'b1, 1'b1, 8, 1'b0);
    pop_chk(1'b0, 10'h2b5);
  endtask : t_sizes

  task automatic t_glitch();
    cfg(1'b0, 4'h8);
    u_tx.send(10'h096, 8, 1'b0, 1'b1, 16, 1'b1);
    pop_chk(1'b0, 10'h096);
    cfg(1'b1, 4'h9);
    u_tx.send(10'h169, 9, 1'b1, 1'b1, 8, 1'b1);
    pop_chk(1'b0, 10'h169);
  endtask : t_glitch

  task automatic t_frame_err();
    cfg(1'b0, 4'h8);
    u_tx.send(10'h05a, 8, 1'b0, 1'b0, 16, 1'b0);
    u_tx.send(10'h0c3, 8, 1'b0, 1'b1, 32, 1'b0);
    pop_chk(1'b1, 10'h05a);
    pop_chk(1'b0, 10'h0c3);
  endtask : t_frame_err

  task automatic t_noise();
    cfg(1'b0, 4'h8);
    u_tx.spike(3);
    chk({10'h000, busy_o}, 11'h001, "start hunt not begun");
    repeat (14) u_tx.wait_tick();
    chk({9'h000, busy_o, rx_valid_o}, 11'h000, "spike accepted");
  endtask : t_noise

  task automatic t_early();
    cfg(1'b0, 4'h8);
    u_tx.send(10'h011, 8, 1'b0, 1'b1, 10, 1'b0);
    u_tx.send(10'h0ee, 8, 1'b0, 1'b1, 16, 1'b0);
    pop_chk(1'b0, 10'h011);
    pop_chk(1'b0, 10'h0ee);
  endtask : t_early

  // three frames into a two-entry buffer with the consumer stalled
  task automatic t_overrun();
    cfg(1'b0, 4'h8);
    ovr_before = ovr_cnt;
    u_tx.send(10'h001, 8, 1'b0, 1'b1, 16, 1'b0);
    u_tx.send(10'h002, 8, 1'b0, 1'b1, 16, 1'b0);
    u_tx.send(10'h003, 8, 1'b0, 1'b1, 16, 1'b0);
    chk(11'(ovr_cnt - ovr_before), 11'h001, "overrun pulses");
    pop_chk(1'b0, 10'h001);
    pop_chk(1'b0, 10'h002);
    chk({10'h000, rx_valid_o}, 11'h000, "buffer not empty");
  endtask : t_overrun

  //============================================================================
  // main sequence and watchdog
  initial begin
    n_fail = 0;
    cmp_count = 0;
    srst_i = 1'b1;
    rx_ready_i = 1'b0;
    double_speed_select_i = 1'b0;
    frame_bits_i = 4'h8;
    repeat (10) @(negedge clock_i);
    srst_i = 1'b0;
    repeat (8) @(negedge clock_i);
    t_modes();
    t_sizes();
    t_glitch();
    t_frame_err();
    t_noise();
    t_early();
    t_overrun();
    wrap_up();
  end
  initial begin
    #400000;
    n_fail++;
    wrap_up();
  end
endmodule : tb
